// [tgm_consts.vh]
// constants for the timing generator and operating-mode controller
// assumes: included by bare name from design files; definitions only
`ifndef TGM_CONSTS_VH
`define TGM_CONSTS_VH
`define TGM_PRE_W       2
`define TGM_DIV_W       21
`define TGM_DIV_STAGE7  6
`define TGM_DIV_STAGE6  5
`define TGM_DVO_BIT     12
`define TGM_TICK_FAST   14
`define TGM_TICK_SLOW   20
`define TGM_STATE_N     2'h3
`define TGM_MCYC_MAX    4'h9
`define TGM_WARM_CYCLES 16'h0400
`define TGM_A_CTRL      12'h000
`define TGM_A_STAT      12'h004
`define TGM_A_DIV       12'h008
`define TGM_B_XEN       7
`define TGM_B_SLOW_OSC_ENABLE      6
`define TGM_B_CPU_CLOCK_SELECT     5
`define TGM_B_DOZE      4
`define TGM_B_GATE      3
`define TGM_B_DV7       2
`define TGM_B_TICK_TIMER_ENABLE     1
`define TGM_B_TICK_SOURCE_SELECT     0
`define TGM_B_STOP      15
`define TGM_B_RELM      14
`define TGM_B_RETM      13
`define TGM_CTRL_RST    16'h0080
`endif

// [tgm_top.v]
// timing generator, divider chain and operating-mode controller
// assumes: one clock pclk; oscillator enables and ticks arrive synchronous
`timescale 1ns/1ps
`default_nettype none
`include "tgm_consts.vh"
module tgm_top (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        clk_en,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        fast_tick,
	input  wire        slow_tick,
	input  wire        irq_request,
	input  wire        interrupt_master_enable,
	input  wire        tick_irq_enable,
	input  wire        stop_pin,
	input  wire [3:0]  instr_cycles,
	output wire        cpu_clk_en,
	output wire        wdt_clk_en,
	output wire        periph_clk_en,
	output wire        tick_clk_en,
	output reg  [1:0]  state_q,
	output wire        cycle_end,
	output wire        instr_done,
	output wire        slow_pins_are_ports,
	output wire        divider_output,
	output wire [20:0] div_taps,
	output reg         tick_interrupt,
	output wire        take_irq_first
);
// ====================================================================
// mode encodings
localparam [10:0] M_RFS = 11'h001;
localparam [10:0] M_RFD = 11'h002;
localparam [10:0] M_RSX = 11'h004;
localparam [10:0] M_RSN = 11'h008;
localparam [10:0] M_DFS = 11'h010;
localparam [10:0] M_DFD = 11'h020;
localparam [10:0] M_DZF = 11'h040;
localparam [10:0] M_DSX = 11'h080;
localparam [10:0] M_DSN = 11'h100;
localparam [10:0] M_DZS = 11'h200;
localparam [10:0] M_STP = 11'h400;
reg [10:0] mode_q;
reg [10:0] mode_d;
reg [15:0] ctrl_q;
reg [1:0]  pre_q;
reg [20:0] div_q;
reg [3:0]  mcyc_q;
reg        stop_from_fast_q, warm_q, tick_en_entry_q;
reg [15:0] warm_cnt_q;
reg        stop_pin_q, tick_src_q, slow_q;
wire fast_osc_enable  = ctrl_q[`TGM_B_XEN];
wire slow_osc_enable = ctrl_q[`TGM_B_SLOW_OSC_ENABLE];
wire cpu_clock_select = ctrl_q[`TGM_B_CPU_CLOCK_SELECT];
wire dv7  = ctrl_q[`TGM_B_DV7];
wire tick_timer_enable = ctrl_q[`TGM_B_TICK_TIMER_ENABLE];
wire is_slow = |(mode_q & (M_RSX | M_RSN | M_DSX | M_DSN | M_DZS));
wire is_xoff = |(mode_q & (M_RSX | M_DSX | M_DSN | M_DZS));
wire is_doze = |(mode_q & (M_DFS | M_DFD | M_DSX | M_DSN));
wire is_deep = |(mode_q & (M_DZF | M_DZS));
wire single  = |(mode_q & (M_RFS | M_DFS | M_DZF)) ||
	(mode_q == M_STP && !slow_osc_enable);
// ====================================================================
// apb slave, zero wait states
wire wr = psel & penable & pwrite & clk_en;
assign pready  = 1'b1;
assign pslverr = psel & penable & (paddr != `TGM_A_CTRL) &
	(paddr != `TGM_A_STAT) & (paddr != `TGM_A_DIV);
reg [31:0] rd_mux;
always @* begin
	case (paddr)
	`TGM_A_CTRL: rd_mux = {16'h0000, ctrl_q};
	`TGM_A_STAT: rd_mux = {16'h0000, mode_q[10:0], warm_q, tick_interrupt,
		2'h0, slow_q};
	`TGM_A_DIV:  rd_mux = {11'h000, div_q};
	default:     rd_mux = 32'h0000_0000;
	endcase
end
// captured in the setup cycle so the word stands through the access phase
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h0000_0000;
	end else if (clk_en && psel && !penable) begin
		prdata <= rd_mux;
	end
end
// ====================================================================
// divider chain; slow modes other than M_RSN stop stages one to six
wire [2:0] pre_n = {1'b0, pre_q} + 3'h1;
wire adv_low = fast_tick & ~is_xoff & (mode_q != M_STP) & (pre_q == 2'h3);
reg stage7_in;
always @* begin
	if (is_slow)
		stage7_in = slow_tick;
	else if (warm_q && stop_from_fast_q)
		stage7_in = adv_low && (div_q[`TGM_DIV_STAGE6:0] == 6'h3f);
	else if (dv7)
		stage7_in = slow_tick;
	else
		stage7_in = adv_low && (div_q[`TGM_DIV_STAGE6:0] == 6'h3f);
end
wire stop_edge = (mode_d == M_STP) != (mode_q == M_STP);
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pre_q <= 2'h0;
		div_q <= 21'h00_0000;
	end else if (clk_en) begin
		if (stop_edge) begin
			pre_q <= 2'h0;
			div_q <= 21'h00_0000;
		end else begin
			if (fast_tick && !is_xoff && mode_q != M_STP)
				pre_q <= pre_n[1:0];
			if (adv_low)
				div_q[5:0] <= div_q[5:0] + 6'h01;
			if (stage7_in)
				div_q[20:6] <= div_q[20:6] + 15'h0001;
		end
	end
end
assign div_taps = div_q;
assign divider_output = div_q[`TGM_DVO_BIT];
// ====================================================================
// main clock, states and machine cycles
// gated by the enable so no cycle end is flagged while state is frozen
wire main_tick = clk_en & (slow_q ? slow_tick : fast_tick);
assign cycle_end = main_tick & (state_q == `TGM_STATE_N);
assign instr_done = cycle_end & (mcyc_q == instr_cycles - 4'h1);
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		state_q <= 2'h0;
		mcyc_q <= 4'h0;
		slow_q <= 1'b0;
	end else if (clk_en) begin
		if (main_tick)
			state_q <= state_q + 2'h1;
		if (cycle_end && is_slow != slow_q)
			slow_q <= is_slow;
		if (cycle_end)
			mcyc_q <= (instr_done || mcyc_q == `TGM_MCYC_MAX) ?
				4'h0 : mcyc_q + 4'h1;
	end
end
// ====================================================================
// mode controller
wire tick_src = ctrl_q[`TGM_B_TICK_SOURCE_SELECT] ? div_q[`TGM_TICK_FAST] :
	div_q[`TGM_TICK_SLOW];
wire tick_fall = tick_src_q & ~tick_src;
wire stop_rel = ctrl_q[`TGM_B_RELM] ? stop_pin : (stop_pin & ~stop_pin_q);
always @* begin
	mode_d = mode_q;
	case (mode_q)
	M_RFS, M_RFD: begin
		if (ctrl_q[`TGM_B_STOP]) mode_d = M_STP;
		else if (ctrl_q[`TGM_B_GATE]) mode_d = M_DZF;
		else if (ctrl_q[`TGM_B_DOZE])
			mode_d = (mode_q == M_RFS) ? M_DFS : M_DFD;
		else if (slow_osc_enable && cpu_clock_select) mode_d = M_RSN;
		else if (slow_osc_enable && mode_q == M_RFS) mode_d = M_RFD;
		else if (!slow_osc_enable) mode_d = M_RFS;
	end
	M_RSN: begin
		if (ctrl_q[`TGM_B_STOP]) mode_d = M_STP;
		else if (ctrl_q[`TGM_B_GATE]) mode_d = M_DZS;
		else if (ctrl_q[`TGM_B_DOZE]) mode_d = M_DSN;
		else if (!fast_osc_enable) mode_d = M_RSX;
		else if (!cpu_clock_select) mode_d = M_RFD;
	end
	M_RSX: begin
		if (ctrl_q[`TGM_B_STOP]) mode_d = M_STP;
		else if (ctrl_q[`TGM_B_GATE]) mode_d = M_DZS;
		else if (ctrl_q[`TGM_B_DOZE]) mode_d = M_DSX;
		else if (fast_osc_enable) mode_d = M_RSN;
	end
	M_DFS: if (irq_request) mode_d = M_RFS;
	M_DFD: if (irq_request) mode_d = M_RFD;
	M_DSX: if (irq_request) mode_d = M_RSX;
	M_DSN: if (irq_request) mode_d = M_RSN;
	M_DZF: if (tick_fall) mode_d = M_RFS;
	M_DZS: if (tick_fall) mode_d = M_RSX;
	M_STP: if (stop_rel)
		mode_d = ctrl_q[`TGM_B_RETM] ? M_RSX : (slow_osc_enable ? M_RFD : M_RFS);
	default: mode_d = M_RFS;
	endcase
end
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		mode_q <= M_RFS;
		ctrl_q <= `TGM_CTRL_RST;
		stop_from_fast_q <= 1'b0;
		warm_q <= 1'b0;
		warm_cnt_q <= 16'h0000;
		tick_en_entry_q <= 1'b0;
		tick_interrupt <= 1'b0;
		stop_pin_q <= 1'b0;
		tick_src_q <= 1'b0;
	end else if (clk_en) begin
		mode_q <= mode_d;
		stop_pin_q <= stop_pin;
		tick_src_q <= tick_src;
		if (wr && paddr == `TGM_A_CTRL)
			ctrl_q <= pwdata[15:0];
		else if (mode_d != mode_q) begin
			// self-clearing start bits once the mode is taken
			ctrl_q[`TGM_B_DOZE] <= 1'b0;
			ctrl_q[`TGM_B_GATE] <= 1'b0;
			ctrl_q[`TGM_B_STOP] <= 1'b0;
		end
		if (mode_d == M_STP && mode_q != M_STP)
			stop_from_fast_q <= ~is_slow;
		if (mode_q == M_STP && mode_d != M_STP) begin
			warm_q <= 1'b1;
			warm_cnt_q <= `TGM_WARM_CYCLES;
		end else if (warm_q) begin
			warm_cnt_q <= warm_cnt_q - 16'h0001;
			if (warm_cnt_q == 16'h0001)
				warm_q <= 1'b0;
		end
		if ((mode_d == M_DZF || mode_d == M_DZS) && !is_deep)
			tick_en_entry_q <= tick_timer_enable;
		// set wins over a clear write in the same cycle
		if (is_deep && tick_fall && tick_en_entry_q)
			tick_interrupt <= 1'b1;
		else if (wr && paddr == `TGM_A_STAT && pwdata[1])
			tick_interrupt <= 1'b0;
	end
end
// ====================================================================
// clock gates
wire hold = warm_q | (mode_q == M_STP);
assign cpu_clk_en = ~is_doze & ~is_deep & ~hold;
assign wdt_clk_en = ~is_doze & ~is_deep & ~hold;
assign periph_clk_en = ~is_deep & ~hold;
assign tick_clk_en = (mode_q != M_STP);
assign slow_pins_are_ports = single;
assign take_irq_first = interrupt_master_enable & irq_request &
	(tick_interrupt ? tick_irq_enable & tick_timer_enable : 1'b1);
endmodule // tgm_top
`default_nettype wire

// [tgm_top_monitor.sv]
// checker for the timing generator and mode controller
// assumes: bound to tgm_top, one clock pclk, reset presetn
`timescale 1ns/1ps
`default_nettype none
module tgm_top_monitor (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       clk_en,
	input wire logic       cpu_clk_en,
	input wire logic       wdt_clk_en,
	input wire logic       periph_clk_en,
	input wire logic       interrupt_master_enable,
	input wire logic       take_irq_first,
	input wire logic       cycle_end,
	input wire logic       instr_done,
	input wire logic [1:0] state_q
);
	// ==========================================================
	// properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_END_AT_S3: assert property (cycle_end |-> state_q == 2'h3)
		else $error("cycle end outside last state");
	AST_STATE_STEP: assert property ($past(presetn) && $changed(state_q) |->
		state_q == $past(state_q) + 2'h1) else $error("state skipped");
	AST_CYCLE_SPACING: assert property (cycle_end |=> !cycle_end [*3])
		else $error("machine cycle shorter than four states");
	AST_FREEZE: assert property (!clk_en |=> state_q == $past(state_q))
		else $error("state moved while frozen");
	AST_DOZE_WDT: assert property (!cpu_clk_en |-> !wdt_clk_en)
		else $error("watchdog runs with cpu halted");
	AST_GATE_CPU: assert property (!periph_clk_en |-> !cpu_clk_en)
		else $error("cpu runs with peripherals gated");
	AST_INSTR_END: assert property (instr_done |-> cycle_end)
		else $error("instruction ends inside a machine cycle");
	AST_IRQ_FIRST: assert property (
		take_irq_first |-> interrupt_master_enable)
		else $error("interrupt taken first while masked");
	cover property (!cpu_clk_en && periph_clk_en);
	cover property (!periph_clk_en);
	cover property (instr_done);
endmodule // tgm_top_monitor

bind tgm_top tgm_top_monitor u_tgm_top_monitor (.pclk, .presetn, .clk_en,
	.cpu_clk_en, .wdt_clk_en, .periph_clk_en, .interrupt_master_enable,
	.take_irq_first, .cycle_end, .instr_done, .state_q);
`default_nettype wire

// [tgm_core_model.sv]
// model of the cpu core and oscillators around the timing generator
// assumes: bench drives irq_want; oscillator ticks run free
`timescale 1ns/1ps
`default_nettype none
module tgm_core_model #(
	parameter int SLOW_DIV = 8
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       instr_done,
	input  wire logic       irq_want,
	output var  logic       fast_tick,
	output var  logic       slow_tick,
	output var  logic       irq_request,
	output var  logic [3:0] instr_cycles
);
	int cnt_q;
	// ==========================================================
	// oscillators and core
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 0;
			fast_tick <= 1'b0;
			slow_tick <= 1'b0;
			irq_request <= 1'b0;
			instr_cycles <= 4'h1;
		end else begin
			cnt_q <= (cnt_q + 1) % SLOW_DIV;
			fast_tick <= 1'b1;
			slow_tick <= (cnt_q == 0);
			// flag is registered like a peripheral's, one edge late
			irq_request <= irq_want;
			if (instr_done) begin
				instr_cycles <= (instr_cycles == 4'ha) ?
					4'h1 : instr_cycles + 4'h1;
			end
		end
	end
endmodule // tgm_core_model
`default_nettype wire

// [test_timing_gen_mode_control.sv]
// self-checking bench for the timing generator and mode controller
// assumes: tgm_top with zero-wait apb, tgm_core_model as far side
`timescale 1ns/1ps
`default_nettype none
module test_timing_gen_mode_control;
	logic pclk = 0, presetn = 0, clk_en = 1, irq_want = 0;
	logic psel = 0, penable = 0, pwrite = 0, err;
	logic interrupt_master_enable = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r;
	logic pready, pslverr, fast_tick, slow_tick, irq_request, cycle_end;
	logic cpu_clk_en, wdt_clk_en, periph_clk_en, tick_clk_en, instr_done;
	logic slow_pins_are_ports, divider_output, tick_interrupt, take_irq_first;
	logic [1:0] state_q;
	logic [3:0] instr_cycles;
	logic [20:0] div_taps, t;
	int num_errors = 0, n_compared = 0;

	tgm_top u_tgm_top (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .fast_tick, .slow_tick,
		.irq_request, .interrupt_master_enable, .tick_irq_enable(1'b1),
		.stop_pin(1'b1), .instr_cycles, .cpu_clk_en, .wdt_clk_en,
		.periph_clk_en, .tick_clk_en, .state_q, .cycle_end, .instr_done,
		.slow_pins_are_ports, .divider_output, .div_taps, .tick_interrupt,
		.take_irq_first);
	tgm_core_model u_tgm_core_model (.pclk, .presetn, .instr_done, .irq_want,
		.fast_tick, .slow_tick, .irq_request, .instr_cycles);

	always #2.5 pclk = ~pclk;

	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic mode_is(input int b);
		apb(12'h004, 1'b0, 32'h0000_0000);
		chk((r >> 5) & 32'h0000_07ff, 32'h0000_0001 << b);
	endtask
	task automatic wake(input int b);
		interrupt_master_enable <= 1'b1;
		irq_want <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({31'h0, take_irq_first}, 32'h0000_0001);
		mode_is(b);
		irq_want <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	task automatic tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// tests
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(12'h000, 1'b0, 32'h0000_0000);
		chk(r, 32'h0000_0080);
		mode_is(0);
		chk({31'h0, slow_pins_are_ports}, 32'h0000_0001);
		apb(12'h00c, 1'b0, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		$display("test reset done");
		apb(12'h000, 1'b1, 32'h0000_0090);
		mode_is(4);
		chk({31'h0, cpu_clk_en}, 32'h0000_0000);
		wake(0);
		apb(12'h000, 1'b1, 32'h0000_00c0);
		mode_is(1);
		chk({31'h0, slow_pins_are_ports}, 32'h0000_0000);
		apb(12'h000, 1'b1, 32'h0000_00d0);
		mode_is(5);
		wake(1);
		apb(12'h000, 1'b1, 32'h0000_00e0);
		mode_is(3);
		repeat (40) @(posedge pclk);
		apb(12'h004, 1'b0, 32'h0000_0000);
		chk(r & 32'h0000_0001, 32'h0000_0001);
		apb(12'h000, 1'b1, 32'h0000_00f0);
		mode_is(8);
		wake(3);
		$display("test fast and dual modes done");
		apb(12'h000, 1'b1, 32'h0000_0060);
		mode_is(2);
		t = div_taps;
		repeat (20) @(posedge pclk);
		chk({26'h0, div_taps[5:0]}, {26'h0, t[5:0]});
		apb(12'h000, 1'b1, 32'h0000_0070);
		mode_is(7);
		wake(2);
		apb(12'h000, 1'b1, 32'h0000_006b);
		mode_is(9);
		chk({30'h0, periph_clk_en, tick_clk_en}, 32'h0000_0001);
		for (int i = 0; i < 5000 && tick_interrupt !== 1'b1; i++)
			@(posedge pclk);
		repeat (2) @(posedge pclk);
		mode_is(2);
		chk({31'h0, tick_interrupt}, 32'h0000_0001);
		clk_en <= 1'b0;
		repeat (4) @(posedge pclk);
		clk_en <= 1'b1;
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(12'h000, 1'b0, 32'h0000_0000);
		chk(r, 32'h0000_0080);
		mode_is(0);
		$display("test slow modes and second reset done");
		tally_and_finish;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		tally_and_finish;
	end
endmodule // test_timing_gen_mode_control
`default_nettype wire
